// ### hdl/apfc_ctrl.sv
// converter control with threshold comparison and access priority
// Contract
// - compare mode: convert, store, compare, conditional irq
// - condition 0: irq when upper byte >= threshold
// - condition 1: irq when upper byte < threshold
// - each new result overwrites the result register
// - after channel change next end is full time
// - converter stops in standby mode
// - result read served before coincident result write
// - mode/channel write blocks result and irq
// - each sample yields a 10-bit result
// - config write aborts, restarts if start set
// - threshold meets upper byte of left-aligned result
// - conversions run back to back while started
module apfc_ctrl
  import apfc_pkg::*;
(
  // clock and reset
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  // register writes
  input  wire logic         mode_wr,
  input  wire logic         chan_wr,
  input  wire logic         cmpm_wr,
  input  wire logic         thr_wr,
  input  wire logic [7:0]   wr_data,
  // result read
  input  wire logic         result_rd,
  // power state and analog comparator
  input  wire logic         standby,
  input  wire logic         analog_cmp_high,
  // register views
  output logic [7:0]        converter_mode_reg,
  output logic [7:0]        channel_select_reg,
  output logic [7:0]        compare_mode_reg,
  output logic [7:0]        compare_threshold_reg,
  output logic [15:0]       conversion_result_reg,
  output logic [15:0]       result_rd_data,
  // analog side
  output logic [CH_W-1:0]   analog_inputs_sel,
  output logic [RES_W-1:0]  sar_trial,
  output logic              converting,
  // interrupt
  output logic              conversion_end_irq
);
  ////////////////////////////////////////////////////////////////////////
  // comparator input synchroniser
  logic cmp_s1;
  logic cmp_s2;
  always_ff @(posedge core_clk) begin
    cmp_s1 <= analog_cmp_high;
    cmp_s2 <= cmp_s1;
  end

  ////////////////////////////////////////////////////////////////////////
  // register fields and decode
  wire conversion_start_bit     = converter_mode_reg[MODE_START_POS];
  wire converter_enable_bit     = converter_mode_reg[MODE_EN_POS];
  wire threshold_compare_enable = compare_mode_reg[CMP_EN_POS];
  wire compare_condition_select = compare_mode_reg[CMP_COND_POS];
  wire [FR_W-1:0] conversion_time_field =
    converter_mode_reg[MODE_FR_LSB +: FR_W];
  wire [CH_W-1:0] channel_select_field = channel_select_reg[CH_W-1:0];
  wire cfg_wr = mode_wr | chan_wr | cmpm_wr | thr_wr;
  wire blk_wr = mode_wr | chan_wr;
  wire run = conversion_start_bit && !standby;

  logic [CNT_W-1:0] conv_time;
  always_comb begin
    unique case (conversion_time_field)
      3'h0:    conv_time = CONV_T0;
      3'h1:    conv_time = CONV_T1;
      3'h2:    conv_time = CONV_T2;
      3'h4:    conv_time = CONV_T4;
      3'h5:    conv_time = CONV_T5;
      3'h6:    conv_time = CONV_T6;
      default: conv_time = CONV_T0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // register file, one short process per register
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      converter_mode_reg <= MODE_RST;
    end else if (mode_wr) begin
      converter_mode_reg <= wr_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      channel_select_reg <= CHAN_RST;
    end else if (chan_wr) begin
      channel_select_reg <= {5'h00, wr_data[CH_W-1:0]};
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      compare_mode_reg <= CMPM_RST;
    end else if (cmpm_wr) begin
      compare_mode_reg <= {wr_data[7:6], 6'h00};
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      compare_threshold_reg <= THR_RST;
    end else if (thr_wr) begin
      compare_threshold_reg <= wr_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // conversion sequencing
  apfc_state_e      state;
  logic [CNT_W-1:0] cnt;
  wire [CNT_W-1:0] sample_cnt = conv_time - (BIT_STEP * 9'd10);
  wire sample_end = (cnt == sample_cnt);
  // ten decisions, the last on the final count, so the whole result
  // stands in the register when the done cycle begins
  wire tick = (cnt > sample_cnt) && (cnt[2:0] == 3'h7);
  wire last = (cnt == conv_time - 9'd1);
  wire sar_clear = (state != APFC_CONV) || cfg_wr || sample_end;
  wire [RES_W-1:0] sar_value;
  wire             sar_done;

  apfc_sar u_sar (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .clear    (sar_clear),
    .step     (tick),
    .cmp_high (cmp_s2),
    .trial    (sar_value),
    .done     ()
  );
  assign sar_done = last;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state <= APFC_IDLE;
      cnt   <= '0;
    end else if (!run) begin
      state <= APFC_IDLE;
      cnt   <= '0;
    end else if (cfg_wr) begin
      state <= APFC_CONV;
      cnt   <= '0;
    end else begin
      unique case (state)
        APFC_IDLE: begin
          state <= APFC_CONV;
          cnt   <= '0;
        end
        APFC_CONV: begin
          cnt <= cnt + 9'd1;
          if (sar_done) begin
            state <= APFC_DONE;
          end
        end
        APFC_DONE: begin
          state <= APFC_CONV;
          cnt   <= '0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // result latch, compare and interrupt
  wire [15:0] left_res = {sar_value, 6'h00};
  wire [7:0]  upper = left_res[15:8];
  wire ge = (upper >= compare_threshold_reg);
  wire cond_ok = compare_condition_select ? !ge : ge;
  wire store = (state == APFC_DONE) && run && !blk_wr;
  wire irq_ok = !threshold_compare_enable || cond_ok;
  wire conv_busy = (state == APFC_CONV) && run && converter_enable_bit;

  // a read takes the old value, a coincident store lands after it
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      result_rd_data <= RESULT_RST;
    end else if (result_rd) begin
      result_rd_data <= conversion_result_reg;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      conversion_result_reg <= RESULT_RST;
    end else if (store) begin
      conversion_result_reg <= left_res;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      conversion_end_irq <= 1'b0;
    end else begin
      conversion_end_irq <= store && irq_ok;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      analog_inputs_sel <= '0;
      sar_trial         <= '0;
      converting        <= 1'b0;
    end else begin
      analog_inputs_sel <= channel_select_field;
      sar_trial         <= sar_value;
      converting        <= conv_busy;
    end
  end
endmodule // apfc_ctrl

// ### pkg/apfc_pkg.sv
// package: constants for the converter control block
package apfc_pkg;
  localparam int RES_W = 10;
  localparam int CH_W = 3;
  localparam int FR_W = 3;
  localparam int THR_W = 8;
  localparam int CNT_W = 9;
  // mode register field positions
  localparam int MODE_START_POS = 7;
  localparam int MODE_FR_LSB = 3;
  localparam int MODE_EN_POS = 0;
  // compare mode register field positions
  localparam int CMP_EN_POS = 7;
  localparam int CMP_COND_POS = 6;
  // reset values
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] CHAN_RST = 8'h00;
  localparam logic [7:0] CMPM_RST = 8'h00;
  localparam logic [7:0] THR_RST = 8'h00;
  localparam logic [15:0] RESULT_RST = 16'h0000;
  // conversion times in core clocks, per conversion-time code
  localparam logic [CNT_W-1:0] CONV_T0 = 9'h120;
  localparam logic [CNT_W-1:0] CONV_T1 = 9'h0F0;
  localparam logic [CNT_W-1:0] CONV_T2 = 9'h0C0;
  localparam logic [CNT_W-1:0] CONV_T4 = 9'h090;
  localparam logic [CNT_W-1:0] CONV_T5 = 9'h078;
  localparam logic [CNT_W-1:0] CONV_T6 = 9'h060;
  // one bit decision every this many cycles within a conversion
  localparam logic [CNT_W-1:0] BIT_STEP = 9'h008;
  typedef enum logic [1:0] {APFC_IDLE, APFC_CONV, APFC_DONE} apfc_state_e;
endpackage

// ### hdl/apfc_sar.sv
// successive approximation register with one decision per step
module apfc_sar
  import apfc_pkg::*;
(
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  // control
  input  wire logic             clear,
  input  wire logic             step,
  input  wire logic             cmp_high,
  // state
  output logic [RES_W-1:0]      trial,
  output logic                  done
);
  logic [RES_W-1:0] mask;
  wire  [RES_W-1:0] kept = cmp_high ? trial : (trial & ~mask);
  wire  [RES_W-1:0] next_mask = mask >> 1;

  always_ff @(posedge core_clk) begin
    if (!rst_n || clear) begin
      mask  <= {1'b1, {(RES_W-1){1'b0}}};
      trial <= {1'b1, {(RES_W-1){1'b0}}};
      done  <= 1'b0;
    end else if (step && !done) begin
      trial <= kept | next_mask;
      mask  <= next_mask;
      done  <= (next_mask == '0);
    end
  end
endmodule // apfc_sar

// ### bench/apfc_ain_model.sv
// analog source model feeding the converter comparator
module apfc_ain_model
  import apfc_pkg::*;
(
  // per-channel levels and converter taps
  input  wire logic [RES_W-1:0] lvl [8],
  input  wire logic [CH_W-1:0]  analog_inputs_sel,
  input  wire logic [RES_W-1:0] sar_trial,
  // comparator
  output logic                  analog_cmp_high
);
  timeunit 1ns;
  timeprecision 1ps;
  // one when the selected input is at or above the tap
  assign analog_cmp_high = lvl[analog_inputs_sel] >= sar_trial;
endmodule // apfc_ain_model

// ### bench/apfc_ctrl_checker.sv
// port-level assertions for the converter control block
module apfc_ctrl_checker (
  input wire logic core_clk, rst_n, mode_wr, chan_wr, result_rd,
  input wire logic standby, converting, conversion_end_irq,
  input wire logic [7:0] converter_mode_reg, compare_mode_reg,
  input wire logic [7:0] compare_threshold_reg,
  input wire logic [15:0] conversion_result_reg, result_rd_data
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////
  irq_pulse_a:
    assert property (conversion_end_irq |=> !conversion_end_irq)
    else $error("irq longer than one cycle");
  irq_cond_a:
    assert property (conversion_end_irq && $past(compare_mode_reg[7]) |->
      $past(compare_mode_reg[6]) ^ (conversion_result_reg[15:8] >=
      $past(compare_threshold_reg))) else $error("irq against condition");
  result_fmt_a:
    assert property (conversion_result_reg[5:0] == 6'h00)
    else $error("result not left aligned");
  read_first_a:
    assert property (result_rd |=>
      result_rd_data == $past(conversion_result_reg))
    else $error("read did not see old result");
  write_wins_a:
    assert property (mode_wr || chan_wr |=> !conversion_end_irq[*8])
    else $error("irq after config write");
  standby_stop_a:
    assert property (standby |=> !converting)
    else $error("converting in standby");
  standby_irq_a:
    assert property (standby [*2] |=> !conversion_end_irq)
    else $error("irq in standby");
  start_clear_a:
    assert property (!converter_mode_reg[7] && !mode_wr |=> !converting)
    else $error("converting with start clear");
endmodule // apfc_ctrl_checker
bind apfc_ctrl apfc_ctrl_checker i_chk (.core_clk, .rst_n, .mode_wr,
  .chan_wr, .result_rd, .standby, .converting, .conversion_end_irq,
  .converter_mode_reg, .compare_mode_reg, .compare_threshold_reg,
  .conversion_result_reg, .result_rd_data);

// ### bench/apfc_ctrl_tb.sv
// self-checking bench for the converter control block
module apfc_ctrl_tb;
  import apfc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 0, rst_n = 0, mode_wr = 0, chan_wr = 0, cmpm_wr = 0;
  logic thr_wr = 0, result_rd = 0, standby = 0, analog_cmp_high;
  logic converting, conversion_end_irq;
  logic [7:0] wr_data = 8'h00, converter_mode_reg, channel_select_reg;
  logic [7:0] compare_mode_reg, compare_threshold_reg, h;
  logic [15:0] conversion_result_reg, result_rd_data;
  logic [CH_W-1:0] analog_inputs_sel, c;
  logic [RES_W-1:0] sar_trial, lvl [8];
  int n_mismatch = 0, compares = 0, nirq, t, codes[7] = '{0,1,2,4,5,6,7};
  apfc_ctrl i_dut (.*);
  apfc_ain_model i_ain (.*);
  always #2.5 core_clk = ~core_clk;
  always @(negedge core_clk) result_rd <= rst_n && ($urandom % 4 == 0);
  ////////////////////////////////////////////////////////////////////
  function automatic int ct(int k);
    case (k)
      1: return 240; 2: return 192; 4: return 144;
      5: return 120; 6: return 96; default: return 288;
    endcase
  endfunction
  task automatic wr(int k, logic [7:0] d);
    @(negedge core_clk);
    wr_data = d;
    case (k) 0: mode_wr = 1; 1: chan_wr = 1; 2: cmpm_wr = 1;
      default: thr_wr = 1; endcase
    @(negedge core_clk);
    {mode_wr, chan_wr, cmpm_wr, thr_wr} = 4'h0;
  endtask
  task automatic run(int n);
    nirq = 0;
    t = 0;
    repeat (n) begin
      @(negedge core_clk);
      if (conversion_end_irq === 1'b1) nirq++;
      if (nirq == 0) t++;
    end
  endtask
  task automatic chk(logic [15:0] got, logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////
  initial begin
    #200_000;
    n_mismatch++;
    results();
  end
  initial begin
    void'($urandom(32'hBEB40F33));
    foreach (lvl[i]) lvl[i] = 10'h000;
    repeat (12) @(negedge core_clk);
    rst_n = 1;
    wr(0, 8'h01);
    run(2800);
    foreach (codes[i]) begin
      c = 3'($urandom);
      lvl[c] = 10'($urandom);
      wr(0, 8'h81 | 8'(codes[i] << 3));
      wr(1, {5'h00, c});
      run(ct(codes[i]) + 9);
      chk(16'(t >= ct(codes[i]) - 2 && t <= ct(codes[i]) + 4), 16'h1);
      chk(conversion_result_reg, {lvl[c], 6'h00});
      chk(16'(channel_select_reg), 16'(c));
      lvl[c] = ~lvl[c];
      run(ct(codes[i]) + 9);
      chk(16'(nirq), 16'h1);
      chk(conversion_result_reg, {lvl[c], 6'h00});
    end
    wr(0, 8'h31);
    wr(0, 8'h30);
    lvl[c] = 10'($urandom);
    wr(0, 8'hB0);
    run(2 * ct(6) + 12);
    chk(16'(nirq), 16'h2);
    chk(conversion_result_reg, {lvl[c], 6'h00});
    $display("test plain done");
    standby = 1;
    run(300);
    chk(16'(nirq), 16'h0);
    standby = 0;
    run(300);
    chk(16'(nirq > 0), 16'h1);
    $display("test standby done");
    for (int i = 0; i < 4; i++) begin
      wr(0, 8'h01);
      wr(0, 8'h00);
      wr(2, {1'b1, i[1], 6'h00});
      wr(0, 8'h01);
      run(2800);
      h = 8'(1 + $urandom % 255);
      lvl[c] = {h - 8'(!i[0]), 2'($urandom)};
      wr(3, h);
      wr(1, {5'h00, c});
      wr(0, 8'hB1);
      run(250);
      chk(16'(nirq > 0), 16'(i[0] ^ i[1]));
      chk(conversion_result_reg, {lvl[c], 6'h00});
    end
    $display("test compare done");
    results();
  end
endmodule // apfc_ctrl_tb
